// [verilog/period_timer.sv]
// The AXI4-Lite slave port was left to the implementer.
module period_timer
   import period_timer_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   ssp_shift_tick,
   output logic                   pwm_timebase_match,
   output logic                   period_match_irq,
   output logic                   irq
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] period_counter;
   logic [7:0] period_limit;
   control_t   period_timer_control;
   logic [7:0] peripheral_irq_flags_1;
   logic [7:0] peripheral_irq_enables_1;
   logic [1:0] evt_status;
   logic [1:0] evt_mask;

   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data may arrive in either order
   wire       aw_take   = s_axi_awvalid && s_axi_awready;
   wire       w_take    = s_axi_wvalid && s_axi_wready;
   wire       wr_fire   = aw_held && w_held && !s_axi_bvalid;
   wire [7:0] wr_idx    = word_index(aw_addr);
   wire       wr_lane0  = wr_fire && w_strb[0];
   wire [7:0] wbyte     = w_data[7:0];
   wire       wr_ctr    = wr_lane0 && (wr_idx == IDX_COUNTER);
   wire       wr_ctl    = wr_lane0 && (wr_idx == IDX_CONTROL);
   wire       wr_lim    = wr_lane0 && (wr_idx == IDX_LIMIT);
   wire       wr_flg    = wr_lane0 && (wr_idx == IDX_IRQ_FLAGS);
   wire       wr_ena    = wr_lane0 && (wr_idx == IDX_IRQ_ENABLES);
   wire       wr_msk    = wr_lane0 && (wr_idx == IDX_EVT_MASK);
   wire       wr_known  = (wr_idx == IDX_COUNTER) || (wr_idx == IDX_CONTROL) || (wr_idx == IDX_LIMIT) ||
                          (wr_idx == IDX_IRQ_FLAGS) || (wr_idx == IDX_IRQ_ENABLES) ||
                          (wr_idx == IDX_EVT_MASK) || (wr_idx == IDX_EVT_STATUS);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Counting path
   wire        scaler_clear = wr_ctr || wr_ctl;
   wire        tick;
   wire        post_event;
   wire        at_limit = (period_counter == period_limit);
   wire        match    = tick && at_limit;
   match_evt_t evt;

   assign evt.match_raw  = match;
   assign evt.match_post = post_event;

   input_prescaler u_pre (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .clear         (scaler_clear),
      .run           (period_timer_control.timer_run),
      .divide_select (period_timer_control.input_divide_select),
      .tick          (tick)
   );

   match_postscaler u_post (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .clear         (scaler_clear),
      .match         (match),
      .divide_select (period_timer_control.match_divide_select),
      .event_out     (post_event)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_counter <= COUNTER_RST;
      end else if (wr_ctr) begin
         period_counter <= wbyte;
      end else if (match) begin
         period_counter <= COUNTER_RST;
      end else if (tick) begin
         period_counter <= period_counter + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_limit <= LIMIT_RST;
      end else if (wr_lim) begin
         period_limit <= wbyte;
      end
   end

   // Control write loads control and clears both scaler counts; the counter keeps its value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_timer_control <= control_t'(CONTROL_RST[6:0]);
      end else if (wr_ctl) begin
         period_timer_control <= control_t'(wbyte[6:0]);
      end
   end

   // Hardware set wins over a software clear in the same cycle
   wire [7:0] flag_set = 8'(post_event) << FLAG_BIT;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peripheral_irq_flags_1 <= 8'h00;
      end else if (wr_flg) begin
         peripheral_irq_flags_1 <= (wbyte & IRQ_FLAGS_MASK) | flag_set;
      end else begin
         peripheral_irq_flags_1 <= peripheral_irq_flags_1 | flag_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peripheral_irq_enables_1 <= 8'h00;
         evt_mask                 <= 2'h0;
      end else begin
         if (wr_ena) begin
            peripheral_irq_enables_1 <= wbyte & IRQ_FLAGS_MASK;
         end
         if (wr_msk) begin
            evt_mask <= wbyte[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Read channel
   wire [7:0] rd_idx  = word_index(s_axi_araddr);
   wire       rd_take = s_axi_arvalid && s_axi_arready;
   wire       rd_stat = rd_take && (rd_idx == IDX_EVT_STATUS);
   logic [7:0] rd_byte;
   logic       rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (rd_idx)
         IDX_COUNTER:     rd_byte = period_counter;
         IDX_CONTROL:     rd_byte = {1'b0, period_timer_control};
         IDX_LIMIT:       rd_byte = period_limit;
         IDX_IRQ_FLAGS:   rd_byte = peripheral_irq_flags_1;
         IDX_IRQ_ENABLES: rd_byte = peripheral_irq_enables_1;
         IDX_EVT_STATUS:  rd_byte = {6'h00, evt_status};
         IDX_EVT_MASK:    rd_byte = {6'h00, evt_mask};
         default: begin
            rd_byte = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end

   // Sticky event bits cleared by reading; a new event in the read cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_status <= 2'h0;
      end else begin
         evt_status <= (rd_stat ? 2'h0 : evt_status) | evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_take;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ssp_shift_tick     <= 1'b0;
         pwm_timebase_match <= 1'b0;
         period_match_irq   <= 1'b0;
         irq                <= 1'b0;
      end else begin
         ssp_shift_tick     <= match;
         pwm_timebase_match <= match;
         period_match_irq   <= peripheral_irq_flags_1[FLAG_BIT] &&
                               peripheral_irq_enables_1[FLAG_BIT];
         irq                <= |(evt_status & evt_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_wrap_to_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      match && !wr_ctr |=> period_counter == COUNTER_RST) else $error("counter did not wrap at limit");
   chk_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      !period_timer_control.timer_run && !wr_ctr |=> $stable(period_counter)) else $error("counter moved while stopped");
   chk_ctl_keeps_count: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctl |=> period_counter == $past(period_counter)) else $error("control write changed counter");
   chk_flag_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      post_event |=> peripheral_irq_flags_1[FLAG_BIT]) else $error("flag not latched");
   chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      peripheral_irq_flags_1[FLAG_BIT] && !wr_flg |=> peripheral_irq_flags_1[FLAG_BIT]) else $error("flag dropped");
   chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      period_match_irq |-> $past(peripheral_irq_enables_1[FLAG_BIT])) else $error("request without enable");
   chk_post_only_on_match: assert property (@(posedge aclk) disable iff (!aresetn)
      post_event |-> match) else $error("postscaled event without match");
   chk_every_match: assert property (@(posedge aclk) disable iff (!aresetn)
      match && !scaler_clear && period_timer_control.match_divide_select == 4'h0 |-> post_event)
      else $error("1:1 postscale missed a match");
   chk_ssp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      match |=> ssp_shift_tick) else $error("shift tick missing");
   chk_one_to_one: assert property (@(posedge aclk) disable iff (!aresetn)
      period_timer_control.timer_run && period_timer_control.input_divide_select == 2'h0 && !scaler_clear
      |-> tick) else $error("1:1 prescale missed a cycle");
   chk_scaler_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      scaler_clear |=> u_pre.count == 4'h0 && u_post.count == 4'h0) else $error("scaler counters not cleared");
endmodule

// [verilog/period_timer_pkg.sv]
package period_timer_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c;
   localparam logic [7:0] IDX_COUNTER     = 8'h11;
   localparam logic [7:0] IDX_CONTROL     = 8'h12;
   localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
   localparam logic [7:0] IDX_LIMIT       = 8'h92;
   localparam logic [7:0] IDX_EVT_STATUS  = 8'h40;
   localparam logic [7:0] IDX_EVT_MASK    = 8'h41;
   localparam int         ADDR_W          = 10;

   localparam logic [7:0] COUNTER_RST     = 8'h00;
   localparam logic [7:0] LIMIT_RST       = 8'hff;
   localparam logic [7:0] CONTROL_RST     = 8'h00;
   localparam logic [7:0] CONTROL_MASK    = 8'h7f;
   localparam logic [7:0] IRQ_FLAGS_MASK  = 8'hf7;

   localparam int         FLAG_BIT        = 1;
   localparam int         RUN_BIT         = 2;

   localparam logic [1:0] AXI_OKAY        = 2'h0;
   localparam logic [1:0] AXI_SLVERR      = 2'h2;

   typedef struct packed {
      logic [3:0] match_divide_select;
      logic       timer_run;
      logic [1:0] input_divide_select;
   } control_t;

   typedef struct packed {
      logic match_raw;
      logic match_post;
   } match_evt_t;

   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction
endpackage

// [verilog/input_prescaler.sv]
module input_prescaler
   import period_timer_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       clear,
   input  wire logic       run,
   input  wire logic [1:0] divide_select,
   output logic            tick
);
   localparam logic [3:0] DIV1_LAST  = 4'h0;
   localparam logic [3:0] DIV4_LAST  = 4'h3;
   localparam logic [3:0] DIV16_LAST = 4'hf;

   logic [3:0] count;
   logic [3:0] last;

   // Upper bit set selects 1:16 whatever the lower bit
   assign last = divide_select[1] ? DIV16_LAST : (divide_select[0] ? DIV4_LAST : DIV1_LAST);
   assign tick = run && !clear && (count >= last);

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         count <= 4'h0;
      end else if (tick) begin
         count <= 4'h0;
      end else if (run) begin
         count <= count + 4'h1;
      end
   end
endmodule

// [verilog/match_postscaler.sv]
module match_postscaler
   import period_timer_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       clear,
   input  wire logic       match,
   input  wire logic [3:0] divide_select,
   output logic            event_out
);
   logic [3:0] count;

   // Select n gives one event every n+1 matches
   assign event_out = match && !clear && (count >= divide_select);

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         count <= 4'h0;
      end else if (event_out) begin
         count <= 4'h0;
      end else if (match) begin
         count <= count + 4'h1;
      end
   end
endmodule

// [test/period_timer_test.sv]
module period_timer_test
   import period_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   logic              ssp_tick;
   logic              pwm_match;
   logic              match_irq;
   logic              irq;
   int                n_errors;
   int                checks;
   int                seed;
   int                n;
   logic [7:0]        lim;
   logic [3:0]        post;
   logic [3:0]        post_list [3];

   period_timer uut (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .s_axi_awaddr       (awaddr),
      .s_axi_awvalid      (awvalid),
      .s_axi_awready      (awready),
      .s_axi_wdata        (wdata),
      .s_axi_wstrb        (wstrb),
      .s_axi_wvalid       (wvalid),
      .s_axi_wready       (wready),
      .s_axi_bresp        (bresp),
      .s_axi_bvalid       (bvalid),
      .s_axi_bready       (bready),
      .s_axi_araddr       (araddr),
      .s_axi_arvalid      (arvalid),
      .s_axi_arready      (arready),
      .s_axi_rdata        (rdata),
      .s_axi_rresp        (rresp),
      .s_axi_rvalid       (rvalid),
      .s_axi_rready       (rready),
      .ssp_shift_tick     (ssp_tick),
      .pwm_timebase_match (pwm_match),
      .period_match_irq   (match_irq),
      .irq                (irq)
   );

   always #4 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic hang;
      n_errors++;
      close_out();
   endtask

   // Each channel is released on the edge that takes it; the response closes the write
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
      int i;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, exp});
            break;
         end
      end
      if (i == 100) hang();
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
      int i;
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rready <= 1'b0;
            chk(rdata, {24'h000000, d});
            chk({30'h0, rresp}, {30'h0, exp});
            break;
         end
      end
      if (i == 100) hang();
   endtask

   // Cycles until the next raw match pulse
   task automatic wait_tick(output int cnt);
      cnt = 0;
      do begin
         @(posedge aclk);
         #1;
         cnt++;
      end while (ssp_tick !== 1'b1 && cnt < 5000);
      if (cnt >= 5000) hang();
   endtask

   function automatic int div_of(input int ps);
      return (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
   endfunction

   // Both timebase outputs carry the same pre-postscale match
   always @(negedge aclk) begin
      if (aresetn && pwm_match !== ssp_tick) chk({31'h0, pwm_match}, {31'h0, ssp_tick});
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0; aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = 4'hf;
      wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
      n_errors = 0; checks = 0; seed = 13724;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_COUNTER, 8'h00, AXI_OKAY);
      rd(IDX_LIMIT, 8'hff, AXI_OKAY);
      rd(IDX_CONTROL, 8'h00, AXI_OKAY);
      rd(IDX_IRQ_FLAGS, 8'h00, AXI_OKAY);
      rd(IDX_IRQ_ENABLES, 8'h00, AXI_OKAY);
      wr(8'h33, 8'h5a, AXI_SLVERR);
      rd(8'h33, 8'h00, AXI_SLVERR);
      // Stopped timer holds a written count, and a control write keeps it
      wr(IDX_COUNTER, 8'h37, AXI_OKAY);
      repeat (20) @(posedge aclk);
      wr(IDX_CONTROL, 8'h78, AXI_OKAY);
      rd(IDX_COUNTER, 8'h37, AXI_OKAY);
      rd(IDX_CONTROL, 8'h78, AXI_OKAY);
      // Match period is (limit+1) times the prescale ratio, every prescale code
      for (int ps = 0; ps < 4; ps++) begin
         lim = 8'h08 + 8'($random(seed) & 15);
         wr(IDX_LIMIT, lim, AXI_OKAY);
         rd(IDX_LIMIT, lim, AXI_OKAY);
         wr(IDX_CONTROL, 8'h04 | 8'(ps), AXI_OKAY);
         wait_tick(n);
         wait_tick(n);
         chk(n, (int'(lim) + 1) * div_of(ps));
      end
      // Postscale corners and a random value; flag raised on the (p+1)th match
      post_list[0] = 4'h0;
      post_list[1] = 4'hf;
      post_list[2] = 4'($random(seed));
      for (int k = 0; k < 3; k++) begin
         post = post_list[k];
         wr(IDX_CONTROL, 8'h00, AXI_OKAY);
         wr(IDX_COUNTER, 8'h00, AXI_OKAY);
         wr(IDX_IRQ_FLAGS, 8'h00, AXI_OKAY);
         wr(IDX_IRQ_ENABLES, 8'h02, AXI_OKAY);
         wr(IDX_CONTROL, {1'b0, post, 1'b1, 2'b00}, AXI_OKAY);
         n = 0;
         for (int c = 0; c < 3000 && match_irq !== 1'b1; c++) begin
            @(posedge aclk);
            #1;
            if (ssp_tick === 1'b1) n++;
         end
         if (match_irq !== 1'b1) hang();
         chk(n, int'(post) + 1);
      end
      // Flag sticks until written to zero; the enable gates the request
      wr(IDX_CONTROL, 8'h00, AXI_OKAY);
      repeat (30) @(posedge aclk);
      rd(IDX_IRQ_FLAGS, 8'h02, AXI_OKAY);
      wr(IDX_IRQ_ENABLES, 8'h00, AXI_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      chk({31'h0, match_irq}, 32'h0);
      wr(IDX_IRQ_FLAGS, 8'h00, AXI_OKAY);
      rd(IDX_IRQ_FLAGS, 8'h00, AXI_OKAY);
      // Event status: masked interrupt, cleared by reading it
      repeat (3) @(posedge aclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      wr(IDX_EVT_MASK, 8'h01, AXI_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      chk({31'h0, irq}, 32'h1);
      rd(IDX_EVT_STATUS, 8'h03, AXI_OKAY);
      rd(IDX_EVT_STATUS, 8'h00, AXI_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      // A write with lane 0 disabled must leave the register alone
      @(posedge aclk);
      wstrb <= 4'he;
      wr(IDX_LIMIT, 8'h00, AXI_OKAY);
      wstrb <= 4'hf;
      rd(IDX_LIMIT, lim, AXI_OKAY);
      rd(IDX_EVT_MASK, 8'h01, AXI_OKAY);
      close_out();
   end
endmodule
